// ### pkg/csc_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH
`define CSC_OFF_CTRL2      8'h00
`define CSC_OFF_TRIM       8'h04
`define CSC_OFF_STATUS     8'h08
`define CSC_OFF_SRCSEL     8'h0C
`define CSC_BUS_DIVIDER_SEL_HI        7
`define CSC_BUS_DIVIDER_SEL_LO        6
`define CSC_RANGE_BIT      5
`define CSC_HGO_BIT        4
`define CSC_LP_BIT         3
`define CSC_EREQ_BIT       2
`define CSC_EOUT_BIT       1
`define CSC_ESTOP_BIT      0
`define CSC_MODE_HI        3
`define CSC_MODE_LO        2
`define CSC_OSCRDY_BIT     1
`define CSC_FINE_PERIOD_ADJUST_BIT      0
`define CSC_CTRL2_RST      8'h40
`define CSC_TRIM_INIT      8'h80
`define CSC_OSC_INIT_CYC   12'h400
`define CSC_SYNC_STAGES    2
`endif

// ### pkg/csc_pkg.sv
// Types shared by the clock source control block
package csc_pkg;
   typedef enum logic [1:0] {
      CSC_SRC_FLL = 2'h0,
      CSC_SRC_INT = 2'h1,
      CSC_SRC_EXT = 2'h2,
      CSC_SRC_RSV = 2'h3
   } csc_src_e;
   typedef enum {
      CSC_OSC_OFF,
      CSC_OSC_WARM,
      CSC_OSC_READY
   } csc_osc_e;
endpackage

// ### verilog/csc_regs.sv
// Clock source control, trim and status registers with AXI4-Lite access
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "csc_map.svh"
module csc_regs (
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // AXI4-Lite write address and data
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // System status
   input  wire logic               background_debug_mode,
   input  wire logic               stop_mode,
   input  wire logic               osc_clock_alive,
   // Bus divider and clock source
   output logic [1:0]              bus_divider_sel,
   output logic [3:0]              bus_divide_ratio,
   output csc_pkg::csc_src_e       clock_source_sel,
   output logic                    fll_disable,
   // External oscillator controls
   output logic                    osc_range_high,
   output logic                    osc_high_gain_sel,
   output logic                    ext_osc_request,
   output logic                    ext_reference_clock_out,
   output logic                    ext_ref_enable,
   // Internal reference trim
   output logic [7:0]              reference_trim,
   output logic                    fine_period_adjust
);
   import csc_pkg::*;

   logic [7:0]     ctrl2_q;
   logic [7:0]     trim_q = `CSC_TRIM_INIT;
   logic           fine_period_adjust_q = 1'b0;
   logic [1:0]     srcsel_q;
   logic [1:0]     sync_q [`CSC_SYNC_STAGES];
   logic [1:0]     mode_q;
   csc_osc_e       osc_q;
   logic [11:0]    osc_cnt_q;
   logic           aw_q;
   logic           w_q;
   logic [7:0]     awaddr_q;
   logic [31:0]    wdata_q;
   logic [3:0]     wstrb_q;
   logic           ext_mode;
   logic           ext_in_use;
   logic           do_write;
   logic           wr_ctrl2;
   logic           wr_trim;
   logic           wr_status;
   logic           wr_srcsel;
   logic           osc_drop;
   logic [7:0]     status_byte;

   // Decodes a source code into a legal selection; reserved maps to FLL
   function automatic logic [1:0] src_decode(input logic [1:0] code);
      src_decode = (code == 2'h3) ? 2'h0 : code;
   endfunction

   // True when a captured write address falls on the given register
   function automatic logic reg_hit(input logic [7:0] addr,
                                    input logic [7:0] offset);
      reg_hit = (addr[7:2] == offset[7:2]);
   endfunction

   // Write channel capture, address and data in either order
   // Ready stays low while a response waits, so a second write cannot
   // overwrite the captured address before the master takes bresp
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign do_write      = aw_q && w_q && !s_axi_bvalid;

   // One strobe per register; only byte lane zero carries register data
   assign wr_ctrl2  = do_write && wstrb_q[0]
                      && reg_hit(awaddr_q, `CSC_OFF_CTRL2);
   assign wr_trim   = do_write && wstrb_q[0]
                      && reg_hit(awaddr_q, `CSC_OFF_TRIM);
   assign wr_status = do_write && wstrb_q[0]
                      && reg_hit(awaddr_q, `CSC_OFF_STATUS);
   assign wr_srcsel = do_write && wstrb_q[0]
                      && reg_hit(awaddr_q, `CSC_OFF_SRCSEL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q     <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_q     <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_q     <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_q     <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_q     <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
         w_q     <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         // Beyond the last register: slave error, nothing is written
         s_axi_bresp  <= (awaddr_q[7:2] > 6'h03) ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register two, divider resets to divide by two
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl2_q <= `CSC_CTRL2_RST;
      end else if (wr_ctrl2) begin
         ctrl2_q <= wdata_q[7:0];
      end
   end

   // Trim is held across reset; only a power-up initial value is given,
   // so a value copied in by software survives a later reset
   always_ff @(posedge aclk) begin
      if (wr_trim) begin
         trim_q <= wdata_q[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      // Only the fine trim bit of the status register can be written
      if (wr_status) begin
         fine_period_adjust_q <= wdata_q[`CSC_FINE_PERIOD_ADJUST_BIT];
      end
   end

   // Clock source select; the reserved code is stored as the FLL output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         srcsel_q <= 2'h0;
      end else if (wr_srcsel) begin
         srcsel_q <= src_decode(wdata_q[1:0]);
      end
   end

   // Selection passes a synchroniser before the mode status follows it,
   // so software reads a mode only once the switch has settled; only
   // each next stage reads a stage, never the logic around it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < `CSC_SYNC_STAGES; i++) begin
            sync_q[i] <= 2'h0;
         end
         mode_q <= 2'h0;
      end else begin
         sync_q[0] <= srcsel_q;
         for (int i = 1; i < `CSC_SYNC_STAGES; i++) begin
            sync_q[i] <= sync_q[i-1];
         end
         mode_q <= sync_q[`CSC_SYNC_STAGES-1];
      end
   end

   // The external reference is in use when its output is enabled, when the
   // settled selection runs from it, or when the pending one does while the settled mode is FLL
   assign ext_mode   = (mode_q == 2'h2)
                       || (mode_q == 2'h0 && srcsel_q == 2'h2);
   assign ext_in_use = ctrl2_q[`CSC_EOUT_BIT] || ext_mode;

   // Ready drops on the write that clears the request or the output
   // enable, not when the reference merely stops being in use
   assign osc_drop = wr_ctrl2
                     && ((ctrl2_q[`CSC_EREQ_BIT] && !wdata_q[`CSC_EREQ_BIT])
                         || (ctrl2_q[`CSC_EOUT_BIT]
                             && !wdata_q[`CSC_EOUT_BIT]));

   // Oscillator initialisation tracking; counting pauses while the
   // oscillator is not alive, so a slow start-up stretches the wait
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_q     <= CSC_OSC_OFF;
         osc_cnt_q <= 12'h000;
      end else begin
         unique case (osc_q)
            CSC_OSC_OFF: begin
               osc_cnt_q <= 12'h000;
               if (ctrl2_q[`CSC_EREQ_BIT] && ext_in_use) begin
                  osc_q <= CSC_OSC_WARM;
               end
            end
            CSC_OSC_WARM: begin
               if (osc_drop || !ctrl2_q[`CSC_EREQ_BIT] || !ext_in_use) begin
                  osc_q <= CSC_OSC_OFF;
               end else if (osc_clock_alive) begin
                  osc_cnt_q <= osc_cnt_q + 12'h001;
                  if (osc_cnt_q == `CSC_OSC_INIT_CYC - 12'h001) begin
                     osc_q <= CSC_OSC_READY;
                  end
               end
            end
            CSC_OSC_READY: begin
               if (osc_drop) begin
                  osc_q <= CSC_OSC_OFF;
               end
            end
         endcase
      end
   end

   // Status word; the upper nibble is reserved and reads as zero
   assign status_byte = {4'h0, mode_q,
                         osc_q == CSC_OSC_READY, fine_period_adjust_q};

   // Read channel
   // A new read is refused while rvalid stands, so rdata cannot move
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         unique case (s_axi_araddr[7:2])
            6'h00: s_axi_rdata <= {24'h000000, ctrl2_q};
            6'h01: s_axi_rdata <= {24'h000000, trim_q};
            6'h02: s_axi_rdata <= {24'h000000, status_byte};
            6'h03: s_axi_rdata <= {30'h0, srcsel_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Outputs
   // The divider takes effect at once; no handshake with the clock tree
   // Stop gating applies only to the reference output and its enable
   assign bus_divider_sel   = ctrl2_q[`CSC_BUS_DIVIDER_SEL_HI:`CSC_BUS_DIVIDER_SEL_LO];
   assign bus_divide_ratio  = 4'h1 << bus_divider_sel;
   assign clock_source_sel  = csc_src_e'(mode_q);
   assign fll_disable       = ctrl2_q[`CSC_LP_BIT] && !background_debug_mode
                              && mode_q != 2'h0;
   assign osc_range_high    = ctrl2_q[`CSC_RANGE_BIT];
   assign osc_high_gain_sel = ctrl2_q[`CSC_HGO_BIT];
   assign ext_osc_request   = ctrl2_q[`CSC_EREQ_BIT];
   assign ext_reference_clock_out = ctrl2_q[`CSC_EOUT_BIT]
                              && (!stop_mode
                                  || ctrl2_q[`CSC_ESTOP_BIT]);
   assign ext_ref_enable    = stop_mode ? (ctrl2_q[`CSC_ESTOP_BIT]
                              && ext_in_use) : ext_in_use;
   assign reference_trim    = trim_q;
   assign fine_period_adjust = fine_period_adjust_q;
endmodule

// ### test/csc_osc_model.sv
// Crystal oscillator stand-in that starts up a while after being asked
`timescale 1ns/100ps
module csc_osc_model #(
   parameter int START_CYC = 40
) (
   input  wire logic aclk,
   input  wire logic ext_osc_request,
   output logic      osc_clock_alive
);
   int cnt_q = 0;
   // Startup count restarts whenever the request drops
   always_ff @(posedge aclk) begin
      if (!ext_osc_request) cnt_q <= 0;
      else if (cnt_q < START_CYC) cnt_q <= cnt_q + 1;
   end
   assign osc_clock_alive = ext_osc_request && cnt_q >= START_CYC;
endmodule

// ### test/csc_regs_asserts.sv
// Port-level assertions for the clock source control registers
`timescale 1ns/100ps
module csc_regs_asserts import csc_pkg::*; (
   // Clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // Read handshake
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   // Clock controls
   input wire logic              background_debug_mode,
   input wire logic [1:0]        bus_divider_sel,
   input wire logic [3:0]        bus_divide_ratio,
   input wire csc_pkg::csc_src_e clock_source_sel,
   input wire logic              fll_disable,
   input wire logic              ext_reference_clock_out,
   input wire logic              ext_ref_enable,
   input wire logic [7:0]        reference_trim
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_div; bus_divide_ratio == 4'h1 << bus_divider_sel; endproperty
   a_div: assert property (p_div) else $error("bad ratio");
   property p_rdiv; $rose(aresetn) |-> bus_divider_sel == 2'h1; endproperty
   a_rdiv: assert property (p_rdiv) else $error("bad div");
   property p_fll;
      fll_disable |-> !background_debug_mode && clock_source_sel != CSC_SRC_FLL;
   endproperty
   a_fll: assert property (p_fll) else $error("bad fll");
   property p_ref; ext_reference_clock_out |-> ext_ref_enable; endproperty
   a_ref: assert property (p_ref) else $error("bad ref");
   property p_mode; clock_source_sel != CSC_SRC_RSV; endproperty
   a_mode: assert property (p_mode) else $error("bad mode");
   property p_trim;
      @(posedge aclk) disable iff (1'b0)
      $past(aresetn) && !aresetn |=> $stable(reference_trim);
   endproperty
   a_trim: assert property (p_trim) else $error("trim lost");
   property p_rans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rans: assert property (p_rans) else $error("no rvalid");
   property p_rbsy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rbsy: assert property (p_rbsy) else $error("arready busy");
endmodule
bind csc_regs csc_regs_asserts u_chk (
   .aclk                    (aclk),
   .aresetn                 (aresetn),
   .s_axi_arvalid           (s_axi_arvalid),
   .s_axi_arready           (s_axi_arready),
   .s_axi_rvalid            (s_axi_rvalid),
   .background_debug_mode   (background_debug_mode),
   .bus_divider_sel         (bus_divider_sel),
   .bus_divide_ratio        (bus_divide_ratio),
   .clock_source_sel        (clock_source_sel),
   .fll_disable             (fll_disable),
   .ext_reference_clock_out (ext_reference_clock_out),
   .ext_ref_enable          (ext_ref_enable),
   .reference_trim          (reference_trim)
);

// ### test/clock_source_ctrl_status_regs_tb.sv
// Self-checking bench for the clock source control registers
`timescale 1ns/100ps
`include "csc_map.svh"
module clock_source_ctrl_status_regs_tb;
   import csc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic background_debug_mode = 1'b0, stop_mode = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, reference_trim;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, bus_divide_ratio;
   logic [1:0] s_axi_bresp, s_axi_rresp, bus_divider_sel, rsp, m;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, osc_clock_alive, fll_disable, osc_range_high;
   logic osc_high_gain_sel, ext_osc_request, ext_ref_enable;
   logic ext_reference_clock_out, fine_period_adjust;
   logic [7:0] rdv, v, t;
   csc_src_e clock_source_sel;
   int compares = 0, miscompares = 0, n;
   always #2.5 aclk = ~aclk;
   csc_regs dut (
      .aclk                    (aclk),
      .aresetn                 (aresetn),
      .s_axi_awaddr            (s_axi_awaddr),
      .s_axi_awvalid           (s_axi_awvalid),
      .s_axi_awready           (s_axi_awready),
      .s_axi_wdata             (s_axi_wdata),
      .s_axi_wstrb             (s_axi_wstrb),
      .s_axi_wvalid            (s_axi_wvalid),
      .s_axi_wready            (s_axi_wready),
      .s_axi_bresp             (s_axi_bresp),
      .s_axi_bvalid            (s_axi_bvalid),
      .s_axi_bready            (s_axi_bready),
      .s_axi_araddr            (s_axi_araddr),
      .s_axi_arvalid           (s_axi_arvalid),
      .s_axi_arready           (s_axi_arready),
      .s_axi_rdata             (s_axi_rdata),
      .s_axi_rresp             (s_axi_rresp),
      .s_axi_rvalid            (s_axi_rvalid),
      .s_axi_rready            (s_axi_rready),
      .background_debug_mode   (background_debug_mode),
      .stop_mode               (stop_mode),
      .osc_clock_alive         (osc_clock_alive),
      .bus_divider_sel         (bus_divider_sel),
      .bus_divide_ratio        (bus_divide_ratio),
      .clock_source_sel        (clock_source_sel),
      .fll_disable             (fll_disable),
      .osc_range_high          (osc_range_high),
      .osc_high_gain_sel       (osc_high_gain_sel),
      .ext_osc_request         (ext_osc_request),
      .ext_reference_clock_out (ext_reference_clock_out),
      .ext_ref_enable          (ext_ref_enable),
      .reference_trim          (reference_trim),
      .fine_period_adjust      (fine_period_adjust)
   );
   csc_osc_model #(.START_CYC(40)) osc (
      .aclk            (aclk),
      .ext_osc_request (ext_osc_request),
      .osc_clock_alive (osc_clock_alive)
   );
   function logic [7:0] stat(input logic [1:0] md, input logic r, f);
      return {4'h0, md, r, f};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      if (miscompares == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task hang;
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish;
   endtask
   // Bus cycles: offer after an edge, sample and release at rising edges
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            rsp = s_axi_bresp;
            break;
         end
      end
      if (n == 20) hang;
      s_axi_bready <= 1'b0;
      @(negedge aclk);
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rdv = s_axi_rdata[7:0];
            rsp = s_axi_rresp;
            break;
         end
      end
      if (n == 20) hang;
      s_axi_rready <= 1'b0;
      @(negedge aclk);
   endtask
   initial begin
      void'($urandom(63347));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`CSC_OFF_CTRL2);
      chk(rdv, `CSC_CTRL2_RST);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         v[7:6] = i[1:0];
         wr(`CSC_OFF_CTRL2, v);
         chk(bus_divide_ratio, 4'h1 << v[7:6]);
         chk(osc_range_high, v[5]);
         chk(osc_high_gain_sel, v[4]);
         chk(ext_reference_clock_out, v[1]);
         chk(ext_osc_request, v[2]);
         rd(`CSC_OFF_CTRL2);
         chk(rdv, v);
      end
      t = $urandom;
      wr(`CSC_OFF_TRIM, t);
      wr(`CSC_OFF_STATUS, 8'hFF);
      rd(`CSC_OFF_STATUS);
      chk(rdv[7:4], 4'h0);
      chk({fine_period_adjust, rdv[0]}, 2'h3);
      chk(reference_trim, t);
      wr(`CSC_OFF_CTRL2, 8'h08);
      for (int i = 1; i < 4; i++) begin
         v = 8'(i % 3);
         m = clock_source_sel;
         wr(`CSC_OFF_SRCSEL, v);
         chk(clock_source_sel, m);
         repeat (4) @(negedge aclk);
         chk(clock_source_sel, v[1:0]);
         chk(fll_disable, v != 8'h00);
         @(posedge aclk) background_debug_mode <= 1'b1;
         @(negedge aclk);
         chk(fll_disable, 1'b0);
         @(posedge aclk) background_debug_mode <= 1'b0;
         rd(`CSC_OFF_STATUS);
         chk(rdv, stat(v[1:0], 1'b0, 1'b1));
      end
      wr(`CSC_OFF_SRCSEL, 8'h03);
      rd(`CSC_OFF_SRCSEL);
      chk(rdv, 8'h00);
      wr(`CSC_OFF_CTRL2, 8'h06);
      rd(`CSC_OFF_STATUS);
      chk(rdv[1], 1'b0);
      chk(ext_reference_clock_out, 1'b1);
      for (int i = 0; i < 600 && !rdv[1]; i++) rd(`CSC_OFF_STATUS);
      chk(rdv[1], 1'b1);
      @(posedge aclk) stop_mode <= 1'b1;
      @(negedge aclk);
      chk(ext_reference_clock_out, 1'b0);
      wr(`CSC_OFF_CTRL2, 8'h07);
      chk({ext_reference_clock_out, ext_ref_enable}, 2'h3);
      rd(`CSC_OFF_STATUS);
      chk(rdv[1], 1'b1);
      @(posedge aclk) stop_mode <= 1'b0;
      wr(`CSC_OFF_CTRL2, 8'h05);
      rd(`CSC_OFF_STATUS);
      chk({rdv[1], ext_reference_clock_out}, 2'h0);
      wr(8'h10, 8'hFF);
      chk(rsp, 2'h2);
      rd(8'h10);
      chk({rsp, rdv}, 10'h200);
      @(posedge aclk) aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`CSC_OFF_TRIM);
      chk(rdv, t);
      chk({fine_period_adjust, bus_divider_sel}, 3'h5);
      tally_and_finish;
   end
endmodule
